// >>> design/ssd_host.sv
// Host end: shifts a ten-bit word out, then pulses enable.
// Assumes the device synchronises the pins; cascade is synchronised here.
`timescale 1ns/1ps
module ssd_host
(
	// System
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_nrst,
	// Link
	ssd_if.host                                link,
	// User request
	input  wire logic                          i_start,
	input  wire logic [ssd_pkg::SSD_STAGES-1:0] i_word,
	// Status
	output logic                               o_busy,
	output logic                               o_done,
	output logic                               o_cascade
);
	import ssd_pkg::*;

	ssd_state_t state;
	logic [3:0] half_cnt;
	logic       half_tick;
	logic [3:0] bit_cnt;
	logic [3:0] gap_cnt;
	logic [9:0] word;
	logic       sclk;
	logic       sdata;
	logic       enable;
	logic       c_meta;

	assign link.sclk   = sclk;
	assign link.sdata  = sdata;
	assign link.enable = enable;

	// ************************************************************
	// Half bit divider
	// ************************************************************
	// Bit period from divider
	// Free running; idle phases simply ignore it
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			half_cnt <= SSD_CNT_ZERO;
		else if (half_cnt == SSD_HALF_LAST)
			half_cnt <= SSD_CNT_ZERO;
		else
			half_cnt <= half_cnt + 4'h1;
	end
	assign half_tick = (half_cnt == SSD_HALF_LAST);

	// ************************************************************
	// Sequencer
	// ************************************************************
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			state   <= SSD_IDLE;
			sclk    <= 1'b0;
			sdata   <= 1'b0;
			enable  <= 1'b0;
			word    <= SSD_WORD_ZERO;
			bit_cnt <= SSD_CNT_ZERO;
			gap_cnt <= SSD_CNT_ZERO;
			o_done  <= 1'b0;
		end
		else
		begin
			o_done <= 1'b0;
			case (state)
				SSD_IDLE:
					if (i_start)
					begin
						// MSB first so it lands in the tenth stage
						word    <= i_word;
						sdata   <= i_word[SSD_STAGES-1];
						bit_cnt <= SSD_CNT_ZERO;
						state   <= SSD_SHIFT;
					end
				SSD_SHIFT:
					if (half_tick)
					begin
						// Data changes only on falling edge
						if (!sclk)
							sclk <= 1'b1;
						else
						begin
							sclk <= 1'b0;
							if (bit_cnt == SSD_BITS_LAST)
							begin
								gap_cnt <= SSD_CNT_ZERO;
								state   <= SSD_WAIT_CE;
							end
							else
							begin
								word    <= {word[SSD_STAGES-2:0], 1'b0};
								sdata   <= word[SSD_STAGES-2];
								bit_cnt <= bit_cnt + 4'h1;
							end
						end
					end
				SSD_WAIT_CE:
					if (half_tick)
					begin
						if (gap_cnt == SSD_CE_HALVES - 4'h1)
						begin
							enable  <= 1'b1;
							gap_cnt <= SSD_CNT_ZERO;
							state   <= SSD_ENABLE;
						end
						else
							gap_cnt <= gap_cnt + 4'h1;
					end
				SSD_ENABLE:
					// Enable held one bit period
					if (half_tick)
					begin
						if (gap_cnt == SSD_EC_HALVES - 4'h1)
						begin
							enable  <= 1'b0;
							gap_cnt <= SSD_CNT_ZERO;
							state   <= SSD_WAIT_EC;
						end
						else
							gap_cnt <= gap_cnt + 4'h1;
					end
				SSD_WAIT_EC:
					// One bit period before clocking again
					if (half_tick)
					begin
						if (gap_cnt == SSD_EC_HALVES - 4'h1)
						begin
							o_done <= 1'b1;
							state  <= SSD_IDLE;
						end
						else
							gap_cnt <= gap_cnt + 4'h1;
					end
				default:
					state <= SSD_IDLE;
			endcase
		end
	end

	// Busy flag registered
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_busy <= 1'b0;
		else
			o_busy <= (state != SSD_IDLE) || i_start;
	end

	// Cascade synchroniser, two flops
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			c_meta    <= 1'b0;
			o_cascade <= 1'b0;
		end
		else
		begin
			c_meta    <= link.cascade;
			o_cascade <= c_meta;
		end
	end
endmodule

// >>> design/ssd_pkg.sv
// Package for the serial solenoid shift driver link.
// Assumes one system clock at 40 MHz on both ends.
package ssd_pkg;
	// ************************************************************
	// Widths and timing
	// ************************************************************
	localparam int          SSD_STAGES      = 10;
	localparam int          SSD_SYS_NS      = 25;
	// Serial bit period in ns, host-generated
	localparam int          SSD_BIT_NS      = 200;
	localparam int          SSD_HALF_CYC    = SSD_BIT_NS / SSD_SYS_NS / 2;
	// Clock-to-enable gap and enable width/gap, in bit periods
	localparam int          SSD_CE_BITS     = 2;
	localparam int          SSD_EC_BITS     = 1;
	localparam logic [3:0]  SSD_HALF_LAST   = 4'(SSD_HALF_CYC - 1);
	localparam logic [3:0]  SSD_CNT_ZERO    = 4'h0;
	localparam logic [3:0]  SSD_BITS_LAST   = 4'(SSD_STAGES - 1);
	localparam logic [3:0]  SSD_CE_HALVES   = 4'(2 * SSD_CE_BITS);
	localparam logic [3:0]  SSD_EC_HALVES   = 4'(2 * SSD_EC_BITS);
	localparam logic [9:0]  SSD_WORD_ZERO   = 10'h000;
	// Host sequencer states
	typedef enum logic [2:0] {SSD_IDLE, SSD_SHIFT, SSD_WAIT_CE, SSD_ENABLE, SSD_WAIT_EC}
		ssd_state_t;
endpackage

// >>> design/ssd_if.sv
// Interface carrying the three-wire link plus cascade output.
// Assumes the bench joins host and device through it.
`timescale 1ns/1ps
interface ssd_if;
	logic sclk;
	logic sdata;
	logic enable;
	logic cascade;
	modport host   (output sclk, output sdata, output enable, input cascade);
	modport device (input sclk, input sdata, input enable, output cascade);
endinterface

// >>> design/ssd_device.sv
// Device end: ten-stage shift register, cascade output, driver outputs.
// Assumes link pins come from another domain; all are synchronised.
//
// Overview of operation
// - Ten stages shift once per serial clock
// - Tenth stage drives the cascade output
// - Data captured on serial clock rising edge
// - Cascade changes on falling edge, always driven
// - Enable transfers register to driver outputs
// - Host waits two bit periods before enable
// - Host waits one bit period after enable
// - Bit period is one serial clock period
`timescale 1ns/1ps
module ssd_device
(
	// System
	input  wire logic                          i_sys_clk,
	input  wire logic                          i_nrst,
	// Link
	ssd_if.device                              link,
	// Solenoid drive, high means sinking
	output logic [ssd_pkg::SSD_STAGES-1:0]     o_drive,
	// Register image for observation
	output logic [ssd_pkg::SSD_STAGES-1:0]     o_shift
);
	import ssd_pkg::*;

	// ************************************************************
	// Input synchronisers
	// ************************************************************
	logic [2:0] meta;
	logic [2:0] sync;
	logic       sclk_d;
	logic       rise;
	logic       fall;

	// Two flops per pin; the first is read only by the second
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
		begin
			meta   <= 3'h0;
			sync   <= 3'h0;
			sclk_d <= 1'b0;
		end
		else
		begin
			meta   <= {link.enable, link.sdata, link.sclk};
			sync   <= meta;
			sclk_d <= sync[0];
		end
	end

	assign rise = sync[0] & ~sclk_d;
	assign fall = ~sync[0] & sclk_d;

	// ************************************************************
	// Shift register
	// ************************************************************
	// Shift on rising edge
	// Data and clock share sync delay, so set-up is preserved
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_shift <= SSD_WORD_ZERO;
		else if (rise)
			o_shift <= {o_shift[SSD_STAGES-2:0], sync[1]};
	end

	// Cascade from last stage on falling edge
	logic cascade;
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			cascade <= 1'b0;
		else if (fall)
			cascade <= o_shift[SSD_STAGES-1];
	end
	assign link.cascade = cascade; // Always driven

	// ************************************************************
	// Driver outputs
	// ************************************************************
	// Transfer while enabled, off otherwise
	always_ff @(posedge i_sys_clk or negedge i_nrst)
	begin
		if (!i_nrst)
			o_drive <= SSD_WORD_ZERO;
		else if (sync[2])
			o_drive <= o_shift;
		else
			o_drive <= SSD_WORD_ZERO;
	end
endmodule

// >>> sim/ssd_chk.sv
// Checker for the serial link wires.
// Assumes both ends share one 40 MHz clock.
`timescale 1ns/1ps
module ssd_chk
(
	// System
	input  wire logic i_sys_clk,
	input  wire logic i_nrst,
	// Link
	input  wire logic sclk,
	input  wire logic sdata,
	input  wire logic enable,
	input  wire logic cascade
);
	// ****************
	// Quiet counter
	// ****************
	logic [4:0] quiet;
	// Cycles with serial clock low, saturates to avoid wrap
	always_ff @(posedge i_sys_clk or negedge i_nrst)
		if (!i_nrst)
			quiet <= 5'h00;
		else if (sclk)
			quiet <= 5'h00;
		else if (quiet != 5'h1f)
			quiet <= quiet + 5'h01;
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_nrst);
	// ****************
	// Assertions
	// ****************
	a_cascade_on_fall: assert property ($changed(cascade) |-> !sclk)
		else $error("cascade moved while clock high");
	a_sclk_high: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
		else $error("clock high phase wrong");
	a_sclk_low: assert property ($fell(sclk) |-> !sclk[*4])
		else $error("clock low phase short");
	a_ce_gap: assert property ($rose(enable) |-> quiet >= 5'h10)
		else $error("enable too soon after clock");
	a_en_width: assert property ($rose(enable) |-> enable[*8] ##1 !enable)
		else $error("enable width wrong");
	a_ec_gap: assert property ($fell(enable) |-> !sclk[*8])
		else $error("clock too soon after enable");
	a_en_no_clk: assert property (enable |-> !sclk)
		else $error("clock high during enable");
	a_data_hold: assert property ($rose(sclk) |-> $stable(sdata)[*4])
		else $error("data moved while clock high");
	c_enable: cover property ($rose(enable));
	c_casc_up: cover property ($rose(cascade));
	c_casc_dn: cover property ($fell(cascade));
endmodule

// >>> sim/serial_solenoid_shift_driver_bench.sv
// Bench joining host and device ends.
// Assumes ssd_pkg and the link interface are compiled first.
`timescale 1ns/1ps
module serial_solenoid_shift_driver_bench;
	import ssd_pkg::*;
	logic                  i_sys_clk = 1'b0;
	logic                  i_nrst = 1'b0;
	logic                  i_start = 1'b0;
	logic [SSD_STAGES-1:0] i_word = SSD_WORD_ZERO;
	logic                  o_busy, o_done, o_cascade;
	logic [SSD_STAGES-1:0] o_drive, o_shift, drv, exp_w;
	logic [SSD_STAGES-1:0] notes[$];
	int                    miscompares = 0;
	int                    num_checks = 0;
	int                    seed = 53;
	ssd_if link();
	ssd_host u_ssd_host (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link),
		.i_start(i_start), .i_word(i_word), .o_busy(o_busy), .o_done(o_done),
		.o_cascade(o_cascade));
	ssd_device u_ssd_device (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link),
		.o_drive(o_drive), .o_shift(o_shift));
	ssd_chk u_ssd_chk (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .sclk(link.sclk),
		.sdata(link.sdata), .enable(link.enable), .cascade(link.cascade));
	// 40 MHz clock
	always #12.5 i_sys_clk = ~i_sys_clk;
	// Compare and count
	task automatic chk(input string name, input logic [SSD_STAGES-1:0] seen, exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic stop_test();
		// A word still queued means its frame never finished
		if (notes.size() != 0)
			miscompares++;
		$display("checks %0d miscompares %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// Start one word once idle; bounded wait on busy
	task automatic send(input logic [SSD_STAGES-1:0] w);
		int n;
		n = 0;
		while (o_busy !== 1'b0 && n < 300)
		begin
			@(negedge i_sys_clk);
			n++;
		end
		// Busy never cleared: count it as a failure
		if (n >= 300)
			miscompares++;
		notes.push_back(w);
		i_word = w;
		i_start = 1'b1;
		@(negedge i_sys_clk);
		i_start = 1'b0;
		@(negedge i_sys_clk);
	endtask
	// Monitor: drive seen during enable, all checked at done
	always @(posedge i_sys_clk)
	begin
		if (link.enable === 1'b1)
			drv <= o_drive;
		if (o_done === 1'b1 && notes.size() > 0)
		begin
			exp_w = notes.pop_front();
			chk("shift", o_shift, exp_w);
			chk("drive", drv, exp_w);
			chk("drive_off", o_drive, SSD_WORD_ZERO);
			chk("cascade", {9'h000, link.cascade}, {9'h000, exp_w[9]});
			chk("o_cascade", {9'h000, o_cascade}, {9'h000, exp_w[9]});
		end
	end
	// Main sequence: edge patterns back to back, random words, reset mid-frame
	initial
	begin
		repeat (3) @(negedge i_sys_clk);
		i_nrst = 1'b1;
		send(10'h3ff);
		send(10'h000);
		send(10'h2aa);
		send(10'h155);
		repeat (4) send(10'($random(seed)));
		send(10'h3ff);
		repeat (40) @(negedge i_sys_clk);
		i_nrst = 1'b0;
		notes.delete();
		@(negedge i_sys_clk);
		chk("reset_shift", o_shift, SSD_WORD_ZERO);
		chk("reset_drive", o_drive, SSD_WORD_ZERO);
		i_nrst = 1'b1;
		send(10'h201);
		repeat (300) @(negedge i_sys_clk);
		stop_test();
	end
	// Watchdog well beyond the expected run
	initial
	begin
		#100000;
		miscompares++;
		stop_test();
	end
endmodule
